// >>> core/xms_addr_decode.sv
// Effective address forming and on-chip or off-chip target decode.
`timescale 1ns/1ns
`default_nettype none
module xms_addr_decode (
    input wire logic wide,
    input wire logic [15:0] ptr,
    input wire logic [7:0] low,
    input wire logic [7:0] page,
    input wire logic [1:0] memMode,
    output logic [15:0] effAddr,
    output logic onChip,
    output logic hiDrive
);

    // ================================================================
    // Address and target
    always_comb
    begin
        effAddr = wide ? ptr : {page, low};
        case (memMode)
            xms_pkg::MODE_INTERNAL: onChip = 1'b1;
            xms_pkg::MODE_EXTERNAL: onChip = 1'b0;
            default: onChip = effAddr < xms_pkg::XRAM_DEPTH;
        endcase
        // The upper byte is left to the port latches for 8-bit forms, except in split-bank mode.
        hiDrive = wide || (memMode == xms_pkg::MODE_SPLIT_BANK);
    end

endmodule : xms_addr_decode
`default_nettype wire

// >>> core/xms_flash_gate.sv
// Flash write and page erase request gating.
`timescale 1ns/1ns
`default_nettype none
module xms_flash_gate #(
    parameter logic [6:0] LOCK_PAGE = xms_pkg::LOCK_PAGE_DFLT
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic go,
    input wire logic eraseEn,
    input wire logic scratchSel,
    input wire logic writeEnable,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    output var xms_pkg::xms_flash_t flashReq,
    output logic eraseRefused
);

    xms_pkg::xms_flash_t flashReqFf;
    logic eraseRefusedFf;
    logic lockHit;

    assign lockHit = !scratchSel &&
        (addr[xms_pkg::ADDR_W-1:xms_pkg::FLASH_PAGE_LSB] == LOCK_PAGE);
    assign flashReq = flashReqFf;
    assign eraseRefused = eraseRefusedFf;

    // ================================================================
    // Request strobes
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            flashReqFf <= '0;
            eraseRefusedFf <= 1'b0;
        end
        else if (ce)
        begin
            flashReqFf.wrStb <= go && writeEnable && !eraseEn;
            flashReqFf.ersStb <= go && writeEnable && eraseEn
                && !lockHit;
            eraseRefusedFf <= go && eraseEn && lockHit;
            if (go)
            begin
                flashReqFf.scratch <= scratchSel;
                flashReqFf.data <= wdata;
                flashReqFf.addr <= scratchSel
                    ? {{(xms_pkg::ADDR_W - xms_pkg::SCRATCH_AW){1'b0}},
                       addr[xms_pkg::SCRATCH_AW-1:0]}
                    : addr;
            end
        end
    end

    // ================================================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    a_flash_write_erase_enable_blocks: assert property (go && !writeEnable |=>
        !flashReqFf.wrStb && !flashReqFf.ersStb)
        else $error("flash request issued while writes disabled");
    a_lock_no_erase: assert property (go && eraseEn && lockHit |=>
        !flashReqFf.ersStb && eraseRefusedFf)
        else $error("lock page erase was not refused");
    a_erase_page: assert property (
        go && writeEnable && eraseEn && !lockHit |=>
        flashReqFf.ersStb && !flashReqFf.wrStb)
        else $error("erase enable did not turn write into erase");
    a_scratch_range: assert property (flashReqFf.scratch |->
        flashReqFf.addr[xms_pkg::ADDR_W-1:xms_pkg::SCRATCH_AW] == '0)
        else $error("scratchpad address out of range");
    c_erase: cover property (go && writeEnable && eraseEn);

endmodule : xms_flash_gate
`default_nettype wire

// >>> core/xms_movx_steering.sv
// MOVX steering: SFRs, on-chip XRAM, off-chip pins and Flash requests.
`timescale 1ns/1ns
`default_nettype none
module xms_movx_steering (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic sfrRdEn,
    input wire logic [7:0] sfrWrData,
    output logic [7:0] sfrRdData,
    input wire logic movxValid,
    input wire xms_pkg::xms_movx_t movxReq,
    output logic movxDone,
    output logic [7:0] movxRdData,
    input wire logic portGroupSelect,
    input wire logic [1:0] memModeSel,
    output var xms_pkg::xms_pins_t pinsOut,
    input wire logic [7:0] pinDataIn,
    output logic lowGroupClaim,
    output logic highGroupClaim,
    output var xms_pkg::xms_flash_t flashReq,
    output logic eraseRefused,
    output logic senseAmpOneshotEn,
    output logic readAlwaysEn
);

    // ================================================================
    // Declarations
    logic [xms_pkg::PSC_USED_W-1:0] progCtlFf;
    logic [7:0] pageSelFf;
    logic [7:0] flashCtlFf;
    logic [7:0] sfrRdDataFf;
    logic [7:0] movxRdDataFf;
    logic movxDoneFf;
    logic lowClaimFf;
    logic highClaimFf;
    xms_pkg::xms_state_t stateFf;
    xms_pkg::xms_state_t nxt_state;
    xms_pkg::xms_movx_t reqFf;
    xms_pkg::xms_pins_t pinsFf;
    logic [7:0] xram [xms_pkg::XRAM_DEPTH];
    logic [15:0] effAddr;
    logic onChip;
    logic hiDrive;
    logic accept;
    logic toFlash;
    logic flashGo;
    logic onAcc;
    logic offAcc;
    logic [xms_pkg::XRAM_AW-1:0] xramIdx;

    assign sfrRdData = sfrRdDataFf;
    assign movxRdData = movxRdDataFf;
    assign movxDone = movxDoneFf;
    assign pinsOut = pinsFf;
    assign lowGroupClaim = lowClaimFf;
    assign highGroupClaim = highClaimFf;
    assign senseAmpOneshotEn = flashCtlFf[xms_pkg::ONESHOT_BIT];
    assign readAlwaysEn = flashCtlFf[xms_pkg::READ_ALWAYS_BIT];

    // ================================================================
    // Special function registers
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            progCtlFf <= xms_pkg::PROG_STORE_CTL_RST[xms_pkg::PSC_USED_W-1:0];
        end
        else if (ce && sfrWrEn && sfrAddr == xms_pkg::PROG_STORE_CTL_ADR)
        begin
            progCtlFf <= sfrWrData[xms_pkg::PSC_USED_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            pageSelFf <= xms_pkg::PAGE_SEL_RST;
        end
        else if (ce && sfrWrEn && sfrAddr == xms_pkg::PAGE_SEL_ADR)
        begin
            pageSelFf <= sfrWrData;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            flashCtlFf <= xms_pkg::FLASH_CTL_RST;
        end
        else if (ce && sfrWrEn && sfrAddr == xms_pkg::FLASH_CTL_ADR)
        begin
            flashCtlFf <= sfrWrData & xms_pkg::FLASH_CTL_MASK;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            sfrRdDataFf <= xms_pkg::RD_UNMAPPED;
        end
        else if (ce && sfrRdEn)
        begin
            case (sfrAddr)
                xms_pkg::PROG_STORE_CTL_ADR:
                    sfrRdDataFf <= {{(8 - xms_pkg::PSC_USED_W){1'b0}},
                                    progCtlFf};
                xms_pkg::PAGE_SEL_ADR: sfrRdDataFf <= pageSelFf;
                xms_pkg::FLASH_CTL_ADR: sfrRdDataFf <= flashCtlFf;
                default: sfrRdDataFf <= xms_pkg::RD_UNMAPPED;
            endcase
        end
    end

    // ================================================================
    // Address forming and request steering
    xms_addr_decode u_decode (
        .wide(movxReq.wide),
        .ptr(movxReq.ptr),
        .low(movxReq.low),
        .page(pageSelFf),
        .memMode(memModeSel),
        .effAddr(effAddr),
        .onChip(onChip),
        .hiDrive(hiDrive)
    );

    assign accept = ce && movxValid && stateFf == xms_pkg::S_IDLE;
    // Only writes are redirected; reads keep normal decoding.
    assign toFlash = movxReq.write
        && progCtlFf[xms_pkg::WRITE_EN_BIT];
    assign flashGo = accept && toFlash;
    assign onAcc = accept && !toFlash && onChip;
    assign offAcc = accept && !toFlash && !onChip;
    assign xramIdx = effAddr[xms_pkg::XRAM_AW-1:0];

    xms_flash_gate u_flash (
        .core_clk(core_clk),
        .reset(reset),
        .ce(ce),
        .go(flashGo),
        .eraseEn(progCtlFf[xms_pkg::ERASE_EN_BIT]),
        .scratchSel(progCtlFf[xms_pkg::SCRATCH_BIT]),
        .writeEnable(flashCtlFf[xms_pkg::FLASH_WE_BIT]),
        .addr(effAddr),
        .wdata(movxReq.wdata),
        .flashReq(flashReq),
        .eraseRefused(eraseRefused)
    );

    // ================================================================
    // On-chip XRAM, aliased on 4 kB boundaries
    always_ff @(posedge core_clk)
    begin
        if (onAcc && movxReq.write)
        begin
            xram[xramIdx] <= movxReq.wdata;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            movxRdDataFf <= '0;
        end
        else if (ce)
        begin
            if (onAcc && !movxReq.write)
            begin
                movxRdDataFf <= xram[xramIdx];
            end
            else if (stateFf == xms_pkg::S_STROBE && !reqFf.write)
            begin
                movxRdDataFf <= pinDataIn;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            movxDoneFf <= 1'b0;
        end
        else if (ce)
        begin
            movxDoneFf <= (accept && (toFlash || onChip))
                || stateFf == xms_pkg::S_RELEASE;
        end
    end

    // ================================================================
    // Off-chip sequencer
    always_comb
    begin
        case (stateFf)
            xms_pkg::S_IDLE:
                nxt_state = offAcc ? xms_pkg::S_ADDR : xms_pkg::S_IDLE;
            xms_pkg::S_ADDR: nxt_state = xms_pkg::S_STROBE;
            xms_pkg::S_STROBE: nxt_state = xms_pkg::S_RELEASE;
            xms_pkg::S_RELEASE: nxt_state = xms_pkg::S_IDLE;
            default: nxt_state = xms_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            stateFf <= xms_pkg::S_IDLE;
        end
        else if (ce)
        begin
            stateFf <= nxt_state;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            reqFf <= '0;
        end
        else if (offAcc)
        begin
            reqFf <= movxReq;
        end
    end

    // Pins carry no output mode; the port mode registers keep it.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            pinsFf <= '0;
            pinsFf.rdStrobe_n <= 1'b1;
            pinsFf.wrStrobe_n <= 1'b1;
        end
        else if (ce)
        begin
            case (stateFf)
                xms_pkg::S_IDLE:
                    if (offAcc)
                    begin
                        pinsFf.addr <= effAddr;
                        pinsFf.addrLoOe <= 1'b1;
                        pinsFf.addrHiOe <= hiDrive;
                        pinsFf.data <= movxReq.wdata;
                        pinsFf.dataOe <= movxReq.write;
                    end
                xms_pkg::S_ADDR:
                begin
                    pinsFf.rdStrobe_n <= reqFf.write;
                    pinsFf.wrStrobe_n <= !reqFf.write;
                end
                xms_pkg::S_STROBE:
                begin
                    pinsFf.rdStrobe_n <= 1'b1;
                    pinsFf.wrStrobe_n <= 1'b1;
                end
                xms_pkg::S_RELEASE:
                begin
                    pinsFf.addrLoOe <= 1'b0;
                    pinsFf.addrHiOe <= 1'b0;
                    pinsFf.dataOe <= 1'b0;
                end
                default:
                begin
                    pinsFf.rdStrobe_n <= 1'b1;
                    pinsFf.wrStrobe_n <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            lowClaimFf <= 1'b0;
            highClaimFf <= 1'b0;
        end
        else if (ce)
        begin
            if (offAcc)
            begin
                lowClaimFf <= !portGroupSelect;
                highClaimFf <= portGroupSelect;
            end
            else if (stateFf == xms_pkg::S_RELEASE)
            begin
                lowClaimFf <= 1'b0;
                highClaimFf <= 1'b0;
            end
        end
    end

    // ================================================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    a_claim_offchip: assert property (
        (pinsFf.addrLoOe || pinsFf.dataOe || lowClaimFf || highClaimFf)
        |-> stateFf != xms_pkg::S_IDLE)
        else $error("pins claimed outside an off-chip access");
    a_offchip_done: assert property (
        offAcc ##1 ce [*3] |-> ##1 movxDoneFf
        && stateFf == xms_pkg::S_IDLE && !pinsFf.addrLoOe)
        else $error("off-chip access did not release in four cycles");
    a_read_undriven: assert property (
        stateFf != xms_pkg::S_IDLE && !reqFf.write |-> !pinsFf.dataOe)
        else $error("data pins driven during a read");
    a_page_form: assert property (
        accept && !movxReq.wide |-> effAddr == {pageSelFf, movxReq.low})
        else $error("8-bit effective address wrong");
    a_wide_form: assert property (
        offAcc && movxReq.wide |=> pinsFf.addr == $past(movxReq.ptr)
        && pinsFf.addrHiOe)
        else $error("16-bit address not driven from the pointer");
    a_default_xram: assert property (
        accept && memModeSel == xms_pkg::MODE_INTERNAL && !toFlash
        |=> stateFf == xms_pkg::S_IDLE && movxDoneFf)
        else $error("internal mode access left the chip");
    a_write_flash: assert property (
        accept && toFlash |=> stateFf == xms_pkg::S_IDLE && movxDoneFf)
        else $error("flash write was sent off-chip");
    a_read_normal: assert property (
        accept && !movxReq.write && !onChip
        |=> stateFf == xms_pkg::S_ADDR)
        else $error("read redirected by flash enables");
    a_group_sel: assert property (
        offAcc && !portGroupSelect |=> lowClaimFf && !highClaimFf)
        else $error("lower port group not selected by zero");
    a_ctl_zero: assert property (
        ce && sfrRdEn && sfrAddr == xms_pkg::PROG_STORE_CTL_ADR
        |=> sfrRdDataFf[7:3] == 5'h00)
        else $error("unused control bits read nonzero");
    a_flash_ctl_wr: assert property (
        ce && sfrWrEn && sfrAddr == xms_pkg::FLASH_CTL_ADR |=>
        flashCtlFf == ($past(sfrWrData) & xms_pkg::FLASH_CTL_MASK))
        else $error("flash control write stored wrong bits");

    c_off_read: cover property (offAcc && !movxReq.write);
    c_off_write: cover property (offAcc && movxReq.write);
    c_on_write: cover property (onAcc && movxReq.write);
    c_flash_write: cover property (flashGo);

endmodule : xms_movx_steering
`default_nettype wire

// >>> core/xms_pkg.sv
// Shared constants and types for the MOVX steering block.
package xms_pkg;

    // ================================================================
    // Register addresses and reset values
    localparam logic [7:0] PROG_STORE_CTL_ADR = 8'h8F;
    localparam logic [7:0] PAGE_SEL_ADR = 8'hA2;
    localparam logic [7:0] FLASH_CTL_ADR = 8'hB7;
    localparam logic [7:0] PROG_STORE_CTL_RST = 8'h00;
    localparam logic [7:0] PAGE_SEL_RST = 8'h00;
    localparam logic [7:0] FLASH_CTL_RST = 8'h80;
    localparam logic [7:0] FLASH_CTL_MASK = 8'hC1;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ================================================================
    // Field positions
    localparam int WRITE_EN_BIT = 0;
    localparam int ERASE_EN_BIT = 1;
    localparam int SCRATCH_BIT = 2;
    localparam int PSC_USED_W = 3;
    localparam int FLASH_WE_BIT = 0;
    localparam int READ_ALWAYS_BIT = 6;
    localparam int ONESHOT_BIT = 7;

    // ================================================================
    // Memory geometry
    localparam int ADDR_W = 16;
    localparam int XRAM_AW = 12;
    localparam int XRAM_DEPTH = 4096;
    localparam int SCRATCH_AW = 7;
    localparam int FLASH_PAGE_LSB = 9;
    localparam int PAGE_NUM_W = ADDR_W - FLASH_PAGE_LSB;
    localparam logic [PAGE_NUM_W-1:0] LOCK_PAGE_DFLT = 7'h7E;

    // ================================================================
    // Types
    typedef enum logic [1:0] {
        MODE_INTERNAL = 2'h0,
        MODE_SPLIT_NOBANK = 2'h1,
        MODE_SPLIT_BANK = 2'h2,
        MODE_EXTERNAL = 2'h3
    } xms_mode_t;

    typedef enum logic [1:0] {
        S_IDLE,
        S_ADDR,
        S_STROBE,
        S_RELEASE
    } xms_state_t;

    typedef struct packed {
        logic write;
        logic wide;
        logic [ADDR_W-1:0] ptr;
        logic [7:0] low;
        logic [7:0] wdata;
    } xms_movx_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic addrHiOe;
        logic addrLoOe;
        logic [7:0] data;
        logic dataOe;
        logic rdStrobe_n;
        logic wrStrobe_n;
    } xms_pins_t;

    typedef struct packed {
        logic wrStb;
        logic ersStb;
        logic scratch;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } xms_flash_t;

endpackage : xms_pkg

// >>> dv/xms_movx_steering_test.sv
// Self-checking bench for the MOVX steering block.
`timescale 1ns/1ns
`default_nettype none
module xms_movx_steering_test;
    logic core_clk, reset, ce, sfrWrEn, sfrRdEn, movxValid, movxDone;
    logic [7:0] sfrAddr, sfrWrData, sfrRdData, movxRdData, pinDataIn;
    logic portGroupSelect, lowGroupClaim, highGroupClaim;
    logic eraseRefused, senseAmpOneshotEn, readAlwaysEn;
    logic [1:0] memModeSel;
    xms_pkg::xms_movx_t movxReq;
    xms_pkg::xms_pins_t pinsOut;
    xms_pkg::xms_flash_t flashReq, fSeen;
    logic [7:0] rdSeen;
    logic [15:0] aSeen;
    logic hiOe, dOe, claimLo, claimHi, rdStb, wrStb, refSeen;
    int num_errors, num_checks, cyc;

    xms_movx_steering dut (.core_clk(core_clk), .reset(reset), .ce(ce),
        .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn),
        .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
        .movxValid(movxValid), .movxReq(movxReq), .movxDone(movxDone),
        .movxRdData(movxRdData), .portGroupSelect(portGroupSelect),
        .memModeSel(memModeSel), .pinsOut(pinsOut), .pinDataIn(pinDataIn),
        .lowGroupClaim(lowGroupClaim), .highGroupClaim(highGroupClaim),
        .flashReq(flashReq), .eraseRefused(eraseRefused),
        .senseAmpOneshotEn(senseAmpOneshotEn), .readAlwaysEn(readAlwaysEn));

    xms_offchip_mem partner (.core_clk(core_clk), .pins(pinsOut),
        .dataOut(pinDataIn));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ================================================================
    // Shared tasks
    task automatic check(input string n, input logic [15:0] e,
        input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        @(negedge core_clk);
        sfrWrEn = 1'b0;
        @(negedge core_clk);
    endtask : sfr_wr

    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e,
        input string n);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        @(negedge core_clk);
        sfrRdEn = 1'b0;
        check(n, {8'h00, e}, {8'h00, sfrRdData});
        @(negedge core_clk);
    endtask : sfr_rd

    // Issues one access and records what the pins did until done.
    task automatic movx(input logic w, input logic wd, input logic [15:0] p,
        input logic [7:0] lo, input logic [7:0] d);
        movxReq = '{w, wd, p, lo, d};
        movxValid = 1'b1;
        {hiOe, dOe, claimLo, claimHi, rdStb, wrStb} = '0;
        aSeen = 16'h0000;
        cyc = 1;
        @(negedge core_clk);
        movxValid = 1'b0;
        while (movxDone !== 1'b1)
        begin
            if (cyc > 8)
            begin
                check("movx timeout", 16'h0001, 16'h0000);
                end_of_test();
            end
            claimLo |= lowGroupClaim;
            claimHi |= highGroupClaim;
            hiOe |= pinsOut.addrHiOe;
            dOe |= pinsOut.dataOe;
            rdStb |= ~pinsOut.rdStrobe_n;
            wrStb |= ~pinsOut.wrStrobe_n;
            if (pinsOut.addrLoOe)
                aSeen = pinsOut.addr;
            @(negedge core_clk);
            cyc++;
        end
        fSeen = flashReq;
        refSeen = eraseRefused;
        rdSeen = movxRdData;
        check("pins released", 16'h0000,
            {lowGroupClaim, highGroupClaim, pinsOut.dataOe});
        @(negedge core_clk);
    endtask : movx

    // ================================================================
    // Scenarios
    task automatic t_regs();
        sfr_rd(8'h8F, 8'h00, "prog ctl reset");
        sfr_rd(8'hA2, 8'h00, "page reset");
        sfr_rd(8'hB7, 8'h80, "flash ctl reset");
        check("oneshot reset", 16'h0001, senseAmpOneshotEn);
        check("read always reset", 16'h0000, readAlwaysEn);
        sfr_wr(8'h8F, 8'hFF);
        sfr_rd(8'h8F, 8'h07, "prog ctl mask");
        sfr_wr(8'hB7, 8'h7F);
        sfr_rd(8'hB7, 8'h41, "flash ctl mask");
        check("oneshot off", 16'h0000, senseAmpOneshotEn);
        check("read always on", 16'h0001, readAlwaysEn);
        sfr_wr(8'hA2, 8'hFF);
        sfr_rd(8'hA2, 8'hFF, "page rw");
        sfr_rd(8'h55, 8'h00, "unmapped");
        sfr_wr(8'h8F, 8'h00);
        sfr_wr(8'hB7, 8'h80);
    endtask : t_regs

    task automatic t_onchip();
        sfr_wr(8'hA2, 8'h0A);
        movx(1'b1, 1'b0, 16'h0000, 8'h34, 8'hC3);
        check("onchip done", 16'h0001, cyc[15:0]);
        check("onchip no pins", 16'h0000, {claimLo, claimHi});
        movx(1'b0, 1'b1, 16'h0A34, 8'h00, 8'h00);
        check("page low read", 16'h00C3, {8'h00, rdSeen});
        movx(1'b0, 1'b1, 16'h1A34, 8'h00, 8'h00);
        check("alias read", 16'h00C3, {8'h00, rdSeen});
    endtask : t_onchip

    task automatic t_offchip();
        portGroupSelect = 1'b0;
        memModeSel = 2'h1;
        sfr_wr(8'hA2, 8'hFF);
        movx(1'b1, 1'b0, 16'h0000, 8'hFF, 8'h5A);
        check("offchip done", 16'h0004, cyc[15:0]);
        check("low group", 16'h0001, {claimHi, claimLo});
        check("write oe", 16'h0003, {dOe, wrStb});
        check("no high addr", 16'h0000, hiOe);
        check("low addr", 16'h00FF, {8'h00, aSeen[7:0]});
        portGroupSelect = 1'b1;
        memModeSel = 2'h2;
        sfr_wr(8'hA2, 8'h20);
        movx(1'b0, 1'b0, 16'h0000, 8'hFF, 8'h00);
        check("high group", 16'h0002, {claimHi, claimLo});
        check("read oe", 16'h0001, {dOe, rdStb});
        check("bank addr", 16'h20FF, aSeen);
        check("offchip data", 16'h005A, {8'h00, rdSeen});
        movx(1'b0, 1'b1, 16'h0A34, 8'h00, 8'h00);
        check("split onchip", 16'h00C3, {8'h00, rdSeen});
        memModeSel = 2'h3;
        movx(1'b0, 1'b1, 16'h0A34, 8'h00, 8'h00);
        check("ext addr", 16'h0A34, aSeen);
        check("ext data", 16'h0034, {8'h00, rdSeen});
        check("ext high oe", 16'h0001, hiOe);
        memModeSel = 2'h0;
    endtask : t_offchip

    task automatic t_flash();
        sfr_wr(8'h8F, 8'h03);
        movx(1'b1, 1'b1, 16'h0400, 8'h00, 8'h11);
        check("blocked", 16'h0000, {fSeen.wrStb, fSeen.ersStb});
        sfr_wr(8'hB7, 8'h81);
        movx(1'b1, 1'b1, 16'h0400, 8'h00, 8'h11);
        check("erase", 16'h0001, fSeen.ersStb);
        movx(1'b1, 1'b1, 16'hFC10, 8'h00, 8'h00);
        check("lock page", 16'h0001, {fSeen.ersStb, refSeen});
        sfr_wr(8'h8F, 8'h01);
        movx(1'b1, 1'b1, 16'h0400, 8'h00, 8'hA5);
        check("flash wr", 16'h0001, fSeen.wrStb);
        check("flash addr", 16'h0400, fSeen.addr);
        check("flash data", 16'h00A5, {8'h00, fSeen.data});
        movx(1'b0, 1'b1, 16'h0A34, 8'h00, 8'h00);
        check("read stays", 16'h00C3, {8'h00, rdSeen});
        check("read no flash", 16'h0000, fSeen.wrStb);
        sfr_wr(8'h8F, 8'h05);
        movx(1'b1, 1'b1, 16'h0015, 8'h00, 8'h66);
        check("scratch", 16'h0003, {fSeen.wrStb, fSeen.scratch});
        check("scratch addr", 16'h0015, fSeen.addr);
    endtask : t_flash

    initial
    begin
        reset = 1'b1;
        ce = 1'b1;
        sfrAddr = 8'h00;
        sfrWrData = 8'h00;
        sfrWrEn = 1'b0;
        sfrRdEn = 1'b0;
        movxValid = 1'b0;
        movxReq = '0;
        portGroupSelect = 1'b0;
        memModeSel = 2'h0;
        num_errors = 0;
        num_checks = 0;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        t_regs();
        t_onchip();
        t_offchip();
        t_flash();
        end_of_test();
    end
endmodule : xms_movx_steering_test
`default_nettype wire

// >>> dv/xms_offchip_mem.sv
// Behavioural off-chip byte memory answering the external strobes.
`timescale 1ns/1ns
`default_nettype none
module xms_offchip_mem (
    input wire logic core_clk,
    input wire xms_pkg::xms_pins_t pins,
    output logic [7:0] dataOut
);
    logic [7:0] mem [0:255];
    logic [7:0] lastVal;
    logic reading;

    initial
    begin
        for (int i = 0; i < 256; i++)
        begin
            mem[i] = 8'(i);
        end
        lastVal = 8'h00;
    end

    assign reading = (pins.rdStrobe_n === 1'b0);

    always @(posedge core_clk)
    begin
        if (pins.wrStrobe_n === 1'b0)
        begin
            mem[pins.addr[7:0]] <= pins.data;
        end
        if (reading)
        begin
            lastVal <= mem[pins.addr[7:0]];
        end
    end

    // A released bus shows the inverse of the last value, never a hold.
    assign dataOut = reading ? mem[pins.addr[7:0]] : ~lastVal;
endmodule : xms_offchip_mem
`default_nettype wire
